//--- ccd_seq_pkg.sv
// Constants and types shared by the readout sequencer, its monitor and its bench
package ccd_seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 20000000;
  localparam int CLOCK_NS = 50;
  // Interval A, nominal 500 ns (0.50 us), within 460..500 ns
  localparam int VA_NS = 500;
  localparam int VA_CYC = VA_NS / CLOCK_NS;
  // Interval B, nominal 1300 ns (1.30 us), within 460..7500 ns
  localparam int VB_NS = 1300;
  localparam int VB_CYC = VB_NS / CLOCK_NS;
  // Photodiode transfer pulse, nominal 1500 ns (1.5 us), within 1..5 us
  localparam int PD_NS = 1500;
  localparam int PD_CYC = PD_NS / CLOCK_NS;
  // Amplifier settle time after power up or flush, in ns
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC = SETTLE_NS / CLOCK_NS;

  // ----------------------------------------------------------------
  // Row timing, in horizontal cycles; row counts and mult delays in rows
  // ----------------------------------------------------------------
  localparam logic [11:0] CLAMP_START = 12'h003;
  localparam logic [11:0] CLAMP_LEN = 12'h01c;
  localparam logic [11:0] FG_FIRST = 12'h022;
  localparam logic [11:0] OUT_FIRST = 12'h044;
  localparam logic [11:0] OUT_LAST = 12'h40c;
  localparam logic [11:0] FG_LAST = OUT_LAST - FG_FIRST;
  localparam logic [11:0] ROW_CYC_MULTI = 12'h40c;
  localparam logic [11:0] ROW_CYC_SINGLE = 12'h818;
  localparam logic [10:0] ROWS_SINGLE = 11'h464;
  localparam logic [10:0] ROWS_MULTI = 11'h232;
  localparam logic [1:0] MULT_DELAY_SINGLE = 2'h1;
  localparam logic [1:0] MULT_DELAY_MULTI = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_DUAL,
    MODE_QUAD
  } out_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_POWER_UP,
    ST_FLUSH,
    ST_SHUTTER,
    ST_EXPOSE,
    ST_FRAME,
    ST_LINE_A,
    ST_LINE_B,
    ST_ROW,
    ST_LONG_DOWN
  } seq_state_t;

endpackage : ccd_seq_pkg

//--- sample_fifo.sv
// Synchronous valid/ready FIFO for captured pixel samples
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire logic full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire logic empty = (wr_q == rd_q);
  wire logic push = in_valid && !full;
  wire logic pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : sample_fifo

//--- ccd_readout_timing_sequencer.sv
// Frame, row and pixel timing sequencer for a four-quadrant multiplying CCD
// How it works
// - Floating-gate output carries first active pixel 34 cycles into row.
// - Normal or multiplied output gets first pixel at 68; switch picks which.
// - Dual/quad multiplied pixel: same row cycle, two rows later.
// - Single-mode multiplied pixel: same row cycle, one row later.
// - Last pixel at output cycle 1036, floating gate 34 cycles earlier.
`timescale 1ns/100ps
module ccd_readout_timing_sequencer
  import ccd_seq_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int FIFO_DEPTH = 32,
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int SHUTTER_CYCLES = PD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic shutter_enable,
  input wire logic long_exposure,
  input wire logic [15:0] exposure_line_count,
  input wire logic route_to_mult,
  input wire logic [SAMPLE_W-1:0] substrate_reference_out,
  input wire logic [SAMPLE_W-1:0] pixel_sample,
  input wire logic pixel_ready,
  output logic [SAMPLE_W-1:0] pixel_data,
  output logic pixel_valid,
  output logic busy,
  output logic clamp,
  output logic fg_pixel_valid,
  output logic normal_pixel_valid,
  output logic mult_pixel_valid,
  output logic first_storage_phase,
  output logic second_storage_phase,
  output logic [3:0] first_barrier_phase,
  output logic [3:0] second_barrier_phase,
  output logic [1:0] cd_storage_high,
  output logic route_switch_normal,
  output logic route_switch_multiplied,
  output logic last_gate_phase,
  output logic extra_gate_phase,
  output logic mult_first_storage_phase,
  output logic mult_first_barrier_phase,
  output logic mult_second_storage_phase,
  output logic mult_second_barrier_phase,
  output logic [3:0] vertical_phase,
  output logic photodiode_transfer,
  output logic shutter_pulse,
  output logic first_amp_power,
  output logic shared_supply_full,
  output logic mult_flush_level,
  output logic [SAMPLE_W-1:0] substrate_hold
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  seq_state_t st_q, st_d;
  out_mode_t mode_q;
  logic [11:0] hcnt_q;
  logic [10:0] row_q;
  logic [15:0] tim_q;
  logic [15:0] exp_q;
  logic hph_q;
  logic [2:0] mrow_q;
  logic woke_q;

  wire logic single = (mode_q == MODE_SINGLE);
  wire logic quad = (mode_q == MODE_QUAD);
  wire logic [11:0] row_len = single ? ROW_CYC_SINGLE : ROW_CYC_MULTI;
  wire logic [10:0] rows = single ? ROWS_SINGLE : ROWS_MULTI;
  wire logic [1:0] mdly = single ? MULT_DELAY_SINGLE : MULT_DELAY_MULTI;
  wire logic row_end = (hcnt_q == row_len - 12'h001);
  wire logic vert = (st_q == ST_FRAME) || (st_q == ST_LINE_A)
    || (st_q == ST_LINE_B) || (st_q == ST_SHUTTER);
  wire logic in_row = (st_q == ST_ROW);
  wire logic [11:0] hpos = hcnt_q + 12'h001;
  // every in-row event below decodes from hpos
  wire logic clamp_d = in_row && (hpos >= CLAMP_START)
    && (hpos < CLAMP_START + CLAMP_LEN);
  wire logic fg_d = in_row && (hpos > FG_FIRST) && (hpos <= FG_LAST);
  wire logic out_win = in_row && (hpos > OUT_FIRST)
    && (hpos <= OUT_LAST);
  // Multiplied path lags by mdly whole rows, same cycle within the row
  wire logic mult_live = (mrow_q >= {1'b0, mdly});
  wire logic [15:0] settle = 16'(SETTLE_CYCLES);
  wire logic tim_done = (tim_q == 16'h0000);
  wire logic fifo_in_ready;
  wire logic fifo_out_valid;
  wire logic [SAMPLE_W-1:0] fifo_out_data;
  wire logic stall = in_row && fg_d && !fifo_in_ready;

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (tim_done) begin
          st_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (tim_done) begin
          // Back from a long exposure the readout follows the flush
          st_d = (shutter_enable && !woke_q) ? ST_SHUTTER : ST_FRAME;
        end
      end
      ST_SHUTTER: begin
        if (tim_done) begin
          st_d = long_exposure ? ST_LONG_DOWN : ST_EXPOSE;
        end
      end
      ST_LONG_DOWN: begin
        if (exp_q == 16'h0000 && tim_done) begin
          st_d = ST_POWER_UP;
        end
      end
      ST_EXPOSE: begin
        if (exp_q == 16'h0000) begin
          st_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (tim_done) begin
          st_d = ST_LINE_A;
        end
      end
      ST_LINE_A: begin
        if (tim_done) begin
          st_d = ST_LINE_B;
        end
      end
      ST_LINE_B: begin
        if (tim_done) begin
          st_d = ST_ROW;
        end
      end
      ST_ROW: begin
        if (row_end && !stall) begin
          st_d = (row_q == rows - 11'h001) ? ST_IDLE : ST_LINE_A;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Load value for the phase timer on entry to each state
  wire logic [15:0] tim_load =
      (st_d == ST_FRAME) ? 16'(PD_CYC - 1)
    : (st_d == ST_LINE_A) ? 16'(VA_CYC - 1)
    : (st_d == ST_LINE_B) ? 16'(VB_CYC - 1)
    : (st_d == ST_SHUTTER) ? 16'(SHUTTER_CYCLES - 1)
    : settle - 16'h0001;
  wire logic entering = (st_d != st_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      mode_q <= MODE_SINGLE;
      tim_q <= 16'h0000;
      exp_q <= 16'h0000;
      hcnt_q <= 12'h000;
      row_q <= 11'h000;
      hph_q <= 1'b0;
      mrow_q <= 3'h0;
      woke_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == ST_LONG_DOWN) begin
        woke_q <= 1'b1;
      end
      if (st_q == ST_IDLE && start) begin
        mode_q <= (mode == 2'h2) ? MODE_QUAD
          : (mode == 2'h1) ? MODE_DUAL : MODE_SINGLE;
        exp_q <= exposure_line_count;
        row_q <= 11'h000;
        mrow_q <= 3'h0;
        woke_q <= 1'b0;
      end
      if (entering) begin
        tim_q <= tim_load;
      end else if (!tim_done) begin
        tim_q <= tim_q - 16'h0001;
      end
      // Exposure counts clock cycles once the settle timer has expired while integrating
      if ((st_q == ST_EXPOSE || st_q == ST_LONG_DOWN) && tim_done
          && exp_q != 16'h0000) begin
        exp_q <= exp_q - 16'h0001;
      end
      if (in_row && !stall) begin
        hph_q <= ~hph_q;
        hcnt_q <= row_end ? 12'h000 : hcnt_q + 12'h001;
        if (row_end) begin
          row_q <= row_q + 11'h001;
          if (mrow_q != 3'h7) begin
            mrow_q <= mrow_q + 3'h1;
          end
        end
      end else if (!in_row) begin
        hcnt_q <= 12'h000;
        hph_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock phases and supplies
  // ----------------------------------------------------------------
  wire logic h1 = vert ? 1'b1 : hph_q;
  wire logic h2 = vert ? 1'b0 : ~hph_q & in_row;
  // b swaps barriers in single; c,d static high unless quad
  wire logic [3:0] b1_d = {quad ? h1 : 1'b1, quad ? h1 : 1'b1,
    single ? h2 : h1, h1};
  wire logic [3:0] b2_d = {quad ? h2 : 1'b1, quad ? h2 : 1'b1,
    single ? h1 : h2, h2};
  wire logic sw_d = in_row && out_win;
  wire logic low_pwr = (st_q == ST_LONG_DOWN);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clamp <= 1'b0;
      fg_pixel_valid <= 1'b0;
      normal_pixel_valid <= 1'b0;
      mult_pixel_valid <= 1'b0;
      first_storage_phase <= 1'b1;
      second_storage_phase <= 1'b0;
      first_barrier_phase <= 4'h0;
      second_barrier_phase <= 4'h0;
      cd_storage_high <= 2'h3;
      route_switch_normal <= 1'b0;
      route_switch_multiplied <= 1'b0;
      last_gate_phase <= 1'b0;
      extra_gate_phase <= 1'b0;
      mult_first_storage_phase <= 1'b1;
      mult_first_barrier_phase <= 1'b1;
      mult_second_storage_phase <= 1'b0;
      mult_second_barrier_phase <= 1'b0;
      vertical_phase <= 4'h0;
      photodiode_transfer <= 1'b0;
      shutter_pulse <= 1'b0;
      first_amp_power <= 1'b0;
      shared_supply_full <= 1'b0;
      mult_flush_level <= 1'b1;
      substrate_hold <= '0;
      busy <= 1'b0;
    end else begin
      busy <= (st_q != ST_IDLE);
      clamp <= clamp_d;
      fg_pixel_valid <= fg_d;
      normal_pixel_valid <= out_win && !route_to_mult;
      mult_pixel_valid <= out_win && route_to_mult && mult_live;
      first_storage_phase <= h1;
      second_storage_phase <= h2;
      first_barrier_phase <= b1_d;
      second_barrier_phase <= b2_d;
      cd_storage_high <= quad ? {h1, h1} : 2'h3;
      route_switch_normal <= sw_d && !route_to_mult;
      route_switch_multiplied <= sw_d && route_to_mult;
      last_gate_phase <= h2;
      extra_gate_phase <= h2;
      mult_first_storage_phase <= vert ? 1'b1 : h1;
      mult_first_barrier_phase <= vert ? 1'b1 : h1;
      mult_second_storage_phase <= h2;
      mult_second_barrier_phase <= h2;
      vertical_phase <= (st_q == ST_LINE_A) ? (quad ? 4'h5 : 4'h3)
        : (st_q == ST_LINE_B) ? (quad ? 4'ha : 4'h6)
        : (st_q == ST_FRAME) ? (quad ? 4'hf : 4'h7) : 4'h0;
      photodiode_transfer <= (st_q == ST_FRAME);
      shutter_pulse <= (st_q == ST_SHUTTER);
      first_amp_power <= !low_pwr && (st_q != ST_IDLE);
      shared_supply_full <= !low_pwr;
      mult_flush_level <= (st_q == ST_FLUSH) || (st_q == ST_POWER_UP)
        || (st_q == ST_IDLE);
      if (st_q == ST_SHUTTER && st_d == ST_LONG_DOWN) begin
        substrate_hold <= substrate_reference_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample buffering
  // ----------------------------------------------------------------
  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fg_d),
    .in_ready(fifo_in_ready),
    .in_data(pixel_sample),
    .out_valid(fifo_out_valid),
    .out_ready(pixel_ready || !pixel_valid),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixel_valid <= 1'b0;
      pixel_data <= '0;
    end else if (pixel_ready || !pixel_valid) begin
      pixel_valid <= fifo_out_valid;
      pixel_data <= fifo_out_data;
    end
  end

endmodule : ccd_readout_timing_sequencer

//--- sensor_model.sv
// Behavioural model of the sensor pins and the pixel sink
`timescale 1ns/100ps
module sensor_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic fg_pixel_valid,
  input wire logic shared_supply_full,
  input wire logic stall,
  output logic [15:0] pixel_sample,
  output logic [15:0] substrate_reference_out,
  output logic pixel_ready
);
  assign pixel_ready = !stall;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixel_sample <= 16'h0000;
      substrate_reference_out <= 16'h5a3c;
    end else begin
      if (fg_pixel_valid)
        pixel_sample <= pixel_sample + 16'h0001;
      // Reference is garbage while the supply is reduced
      substrate_reference_out <= shared_supply_full ? 16'h5a3c :
        ~substrate_reference_out;
    end
  end
endmodule : sensor_model

//--- ccd_seq_monitor.sv
// Concurrent checks on the readout sequencer ports
`timescale 1ns/100ps
module ccd_seq_monitor
  import ccd_seq_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic busy,
  input wire logic clamp,
  input wire logic fg_pixel_valid,
  input wire logic normal_pixel_valid,
  input wire logic mult_pixel_valid,
  input wire logic pixel_valid,
  input wire logic pixel_ready,
  input wire logic first_storage_phase,
  input wire logic second_storage_phase,
  input wire logic [3:0] first_barrier_phase,
  input wire logic [3:0] second_barrier_phase,
  input wire logic [1:0] cd_storage_high,
  input wire logic route_switch_normal,
  input wire logic route_switch_multiplied,
  input wire logic mult_first_storage_phase,
  input wire logic mult_second_storage_phase,
  input wire logic photodiode_transfer,
  input wire logic shutter_pulse,
  input wire logic shared_supply_full,
  input wire logic [SAMPLE_W-1:0] substrate_hold
);
  int clamp_n, pd_n, row_n, row_len;
  logic seen_q, stall_q, out_any, single;
  assign out_any = normal_pixel_valid | mult_pixel_valid;
  assign single = (mode == 2'h0) || (mode == 2'h3);
  // Row period is the horizontal count plus the two line transfer intervals
  assign row_len = (single ? int'(ROW_CYC_SINGLE) : int'(ROW_CYC_MULTI))
    + VA_CYC + VB_CYC;
  // Row length is void when the sink stalled the row
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clamp_n <= 0;
      pd_n <= 0;
      row_n <= 0;
      seen_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      clamp_n <= clamp ? clamp_n + 1 : 0;
      pd_n <= photodiode_transfer ? pd_n + 1 : 0;
      row_n <= $rose(clamp) ? 1 : row_n + 1;
      seen_q <= seen_q | $rose(clamp);
      stall_q <= $rose(clamp) ? 1'b0 : stall_q | (pixel_valid & ~pixel_ready);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_clamp_width: assert property (
    $fell(clamp) |-> clamp_n == int'(CLAMP_LEN)) else $error("clamp width");
  a_row_length: assert property (
    $rose(clamp) && seen_q && !stall_q |-> row_n == row_len)
    else $error("row length");
  a_fg_offset: assert property (
    $rose(clamp) |-> ##32 $rose(fg_pixel_valid)) else $error("fg start");
  a_out_offset: assert property (
    $rose(fg_pixel_valid) |-> ##34 $rose(out_any)) else $error("out start");
  a_fg_last: assert property (
    $fell(fg_pixel_valid) |-> ##34 $fell(out_any)) else $error("out end");
  a_pd_width: assert property (
    $fell(photodiode_transfer) |-> pd_n >= 20 && pd_n <= 100)
    else $error("transfer pulse width");
  a_vert_hold: assert property (
    photodiode_transfer || shutter_pulse |-> first_storage_phase &&
    mult_first_storage_phase && !second_storage_phase &&
    !route_switch_normal && !route_switch_multiplied &&
    !mult_second_storage_phase) else $error("phases in transfer");
  a_unused_high: assert property (
    busy && mode != 2'h2 |-> cd_storage_high == 2'h3 &&
    first_barrier_phase[3:2] == 2'h3 && second_barrier_phase[3:2] == 2'h3)
    else $error("unused register not high");
  a_barrier_mode: assert property (
    fg_pixel_valid |-> (single ?
    first_barrier_phase[1] == second_barrier_phase[0] &&
    second_barrier_phase[1] == first_barrier_phase[0] :
    first_barrier_phase[1] == first_barrier_phase[0] &&
    second_barrier_phase[1] == second_barrier_phase[0]))
    else $error("barrier pattern");
  a_sub_hold: assert property (
    !shared_supply_full && !$past(shared_supply_full) |-> $stable(substrate_hold))
    else $error("substrate hold moved");
  cover property ($rose(clamp));
  cover property ($fell(photodiode_transfer));
  cover property (pixel_valid && !pixel_ready);
endmodule : ccd_seq_monitor
bind ccd_readout_timing_sequencer ccd_seq_monitor #(.SAMPLE_W(SAMPLE_W)) mon (
  .clock, .rst, .mode, .busy, .clamp, .fg_pixel_valid, .normal_pixel_valid,
  .mult_pixel_valid, .pixel_valid, .pixel_ready, .first_storage_phase,
  .second_storage_phase, .first_barrier_phase, .second_barrier_phase,
  .cd_storage_high, .route_switch_normal, .route_switch_multiplied,
  .mult_first_storage_phase, .mult_second_storage_phase,
  .photodiode_transfer, .shutter_pulse, .shared_supply_full, .substrate_hold);

//--- ccd_readout_timing_sequencer_tb.sv
// Self-checking bench for the readout sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module ccd_readout_timing_sequencer_tb
  import ccd_seq_pkg::*;
;
  typedef struct {logic [1:0] m; logic sh; logic le; int len;} case_t;
  case_t cases [4];
  logic clock = 1'b0, rst = 1'b1, start = 1'b0, stall = 1'b0;
  logic shutter_enable = 1'b0, long_exposure = 1'b0, route_to_mult = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] exposure_line_count = 16'h0002;
  logic [15:0] substrate_reference_out, pixel_sample, pixel_data, d;
  logic [15:0] substrate_hold;
  logic pixel_ready, pixel_valid, busy, clamp, fg_pixel_valid;
  logic first_storage_phase, mult_flush_level, shared_supply_full;
  logic [1:0] cd_storage_high;
  int fail_count = 0, n_tests = 0, cyc, hi, px;
  always #25 clock = ~clock;
  ccd_readout_timing_sequencer #(.SETTLE_CYCLES(4)) DUT (.clock, .rst,
    .start, .mode, .shutter_enable, .long_exposure, .exposure_line_count,
    .route_to_mult, .substrate_reference_out, .pixel_sample, .pixel_ready,
    .pixel_data, .pixel_valid, .busy, .clamp, .fg_pixel_valid,
    .normal_pixel_valid(), .mult_pixel_valid(), .first_storage_phase,
    .second_storage_phase(), .first_barrier_phase(),
    .second_barrier_phase(), .cd_storage_high, .route_switch_normal(),
    .route_switch_multiplied(), .last_gate_phase(), .extra_gate_phase(),
    .mult_first_storage_phase(), .mult_first_barrier_phase(),
    .mult_second_storage_phase(), .mult_second_barrier_phase(),
    .vertical_phase(), .photodiode_transfer(), .shutter_pulse(),
    .first_amp_power(), .shared_supply_full, .mult_flush_level,
    .substrate_hold);
  sensor_model SNS (.clock, .rst, .fg_pixel_valid, .shared_supply_full,
    .stall, .pixel_sample, .substrate_reference_out, .pixel_ready);
  task complete_run;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Runs to the next clamp rise, counting cycles, clamp and pixels
  task row_scan;
    int k;
    bit was;
    cyc = 1;
    hi = 1;
    px = 0;
    was = 1'b1;
    for (k = 0; k < 20000; k++) begin
      @(posedge clock);
      #1;
      if (clamp === 1'b1 && !was) break;
      was = (clamp === 1'b1);
      cyc++;
      if (was) hi++;
      if (pixel_valid === 1'b1 && pixel_ready === 1'b1) px++;
    end
    if (k == 20000) begin
      fail_count++;
      $display("[ERR] %0t no row start", $time);
      complete_run();
    end
  endtask : row_scan
  task launch(input case_t c);
    @(posedge clock);
    mode <= c.m;
    shutter_enable <= c.sh;
    long_exposure <= c.le;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
  endtask : launch
  initial begin
    cases[0] = '{2'h0, 1'b1, 1'b0, int'(ROW_CYC_SINGLE)};
    cases[1] = '{2'h1, 1'b0, 1'b0, int'(ROW_CYC_MULTI)};
    cases[2] = '{2'h2, 1'b1, 1'b0, int'(ROW_CYC_MULTI)};
    cases[3] = '{2'h3, 1'b1, 1'b1, int'(ROW_CYC_SINGLE)};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    foreach (cases[i]) begin
      launch(cases[i]);
      row_scan();
      row_scan();
      `CHK(cyc, cases[i].len + VA_CYC + VB_CYC)
      `CHK(substrate_hold, cases[i].le ? 16'h5a3c : 16'h0000)
      `CHK(hi, int'(CLAMP_LEN))
      `CHK(px, int'(FG_LAST - FG_FIRST))
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      #1;
      `CHK(busy, 1'b0)
      `CHK(clamp, 1'b0)
      `CHK(cd_storage_high, 2'h3)
      `CHK(first_storage_phase, 1'b1)
      `CHK(mult_flush_level, 1'b1)
      @(posedge clock);
      rst <= 1'b0;
      $display("mode %0d done", cases[i].m);
    end
    // Sink stalls mid-row for over 40 cycles, past the point the buffer is full
    launch(cases[1]);
    row_scan();
    fork
      row_scan();
      begin
        repeat (100) @(posedge clock);
        stall <= 1'b1;
        @(posedge clock);
        #1;
        d = pixel_data;
        repeat (40) begin
          @(posedge clock);
          #1;
          `CHK(pixel_valid, 1'b1)
          `CHK(pixel_data, d)
        end
        @(posedge clock);
        stall <= 1'b0;
      end
    join
    `CHK(px, int'(FG_LAST - FG_FIRST))
    `CHK(pixel_valid, 1'b0)
    $display("stall done");
    complete_run();
  end
endmodule : ccd_readout_timing_sequencer_tb
